// ---- hw/mgmt_xport_dev.sv ----
// Device end: checks, acknowledges and reassembles fragment frames.
// Assumes the link is driven by the controller end on the same clock.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module mgmt_xport_dev (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Link.
	mgmt_link_if.dev link,
	// Channel recovery.
	input wire logic chan_reinit_i,
	// Delivered message.
	output logic msg_valid_o,
	output logic [15:0] msg_id_o,
	output logic [15:0] msg_opcode_o,
	output logic [7:0] msg_len_o,
	input wire logic [7:0] rd_addr_i,
	output logic [7:0] rd_data_o
);
	// ==========================================================
	// Receive parsing.
	logic [8:0] rx_idx_reg;
	logic hdr_ok_reg;
	logic [7:0] ver_reg;
	logic [7:0] type_reg;
	logic [15:0] seq_reg;
	logic [15:0] tot_reg;
	logic [7:0] len_reg;
	logic frame_ok_reg;
	logic accept_reg;
	logic [7:0] rc_reg;
	logic [7:0] rc_next;
	logic accept_next;
	logic [15:0] exp_seq_reg;
	logic [15:0] prev_seq_reg;
	logic have_prev_reg;
	logic [7:0] wptr_reg;
	logic [7:0] buf_mem [mgmt_xport_pkg::BUF_DEPTH];
	logic [7:0] pay_k;
	logic rx_last;
	logic deliver_reg;
	logic [15:0] id_reg;
	logic [15:0] op_reg;

	assign pay_k = rx_idx_reg[7:0] - mgmt_xport_pkg::POS_PAY[7:0];
	assign rx_last = link.c2d_valid && link.c2d_last;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_idx_reg <= 9'h000;
		end else if (link.c2d_valid) begin
			rx_idx_reg <= link.c2d_last ? 9'h000 : rx_idx_reg + 9'h001;
		end
	end

	// Header capture.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hdr_ok_reg <= 1'b0;
			ver_reg <= 8'h00;
			type_reg <= 8'h00;
			seq_reg <= 16'h0000;
			tot_reg <= 16'h0000;
			len_reg <= 8'h00;
		end else if (link.c2d_valid) begin
			if (rx_idx_reg == mgmt_xport_pkg::POS_CODE) begin
				hdr_ok_reg <= link.c2d_data ==
					mgmt_xport_pkg::CODE_ORG_SPECIFIC;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_OUI0) begin
				hdr_ok_reg <= hdr_ok_reg &&
					link.c2d_data == mgmt_xport_pkg::ORG_ID[23:16];
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_OUI1) begin
				hdr_ok_reg <= hdr_ok_reg &&
					link.c2d_data == mgmt_xport_pkg::ORG_ID[15:8];
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_OUI2) begin
				hdr_ok_reg <= hdr_ok_reg &&
					link.c2d_data == mgmt_xport_pkg::ORG_ID[7:0];
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_VER) begin
				ver_reg <= link.c2d_data;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_TYPE) begin
				type_reg <= link.c2d_data;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_SEQ_HI) begin
				seq_reg[15:8] <= link.c2d_data;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_SEQ_LO) begin
				seq_reg[7:0] <= link.c2d_data;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_TOT_HI) begin
				tot_reg[15:8] <= link.c2d_data;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_TOT_LO) begin
				tot_reg[7:0] <= link.c2d_data;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_LEN) begin
				len_reg <= link.c2d_data;
			end
		end
	end

	// Response decision, made once the whole header is known.
	always_comb begin
		rc_next = mgmt_xport_pkg::RC_VALID;
		accept_next = 1'b0;
		if (ver_reg != mgmt_xport_pkg::TL_VERSION) begin
			rc_next = mgmt_xport_pkg::RC_BAD_VERSION;
		end else if (have_prev_reg && seq_reg == prev_seq_reg &&
			seq_reg != 16'h0000) begin
			// Sequence zero is never taken as a duplicate; an accepted repeat of it restarts the message.
			rc_next = mgmt_xport_pkg::RC_VALID;
		end else if (seq_reg >= tot_reg) begin
			rc_next = mgmt_xport_pkg::RC_TOO_MANY;
		end else if (seq_reg == 16'h0000 || seq_reg == exp_seq_reg) begin
			accept_next = 1'b1;
		end else begin
			rc_next = mgmt_xport_pkg::RC_OUT_OF_SEQ;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_ok_reg <= 1'b0;
			accept_reg <= 1'b0;
			rc_reg <= mgmt_xport_pkg::RC_VALID;
		end else if (link.c2d_valid) begin
			if (rx_idx_reg == mgmt_xport_pkg::POS_CODE) begin
				frame_ok_reg <= 1'b0;
				accept_reg <= 1'b0;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_LEN) begin
				frame_ok_reg <= hdr_ok_reg &&
					type_reg == mgmt_xport_pkg::TYPE_PDU;
				accept_reg <= hdr_ok_reg && accept_next &&
					type_reg == mgmt_xport_pkg::TYPE_PDU;
				rc_reg <= rc_next;
			end
		end
	end

	// Sequence tracking and reassembly.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			exp_seq_reg <= 16'h0000;
			prev_seq_reg <= 16'h0000;
			have_prev_reg <= 1'b0;
			wptr_reg <= 8'h00;
			id_reg <= 16'h0000;
			op_reg <= 16'h0000;
			deliver_reg <= 1'b0;
		end else if (chan_reinit_i) begin
			exp_seq_reg <= 16'h0000;
			have_prev_reg <= 1'b0;
			wptr_reg <= 8'h00;
			deliver_reg <= 1'b0;
		end else begin
			deliver_reg <= 1'b0;
			if (link.c2d_valid && accept_reg &&
				rx_idx_reg >= mgmt_xport_pkg::POS_PAY) begin
				if (seq_reg == 16'h0000 &&
					pay_k < mgmt_xport_pkg::INNER_HDR_LEN) begin
					// The reserved byte is not interpreted.
					if (pay_k == mgmt_xport_pkg::IH_ID_HI) begin
						id_reg[15:8] <= link.c2d_data;
					end else if (pay_k == mgmt_xport_pkg::IH_ID_LO) begin
						id_reg[7:0] <= link.c2d_data;
					end else if (pay_k == mgmt_xport_pkg::IH_OP_HI) begin
						op_reg[15:8] <= link.c2d_data;
					end else if (pay_k == mgmt_xport_pkg::IH_OP_LO) begin
						op_reg[7:0] <= link.c2d_data;
					end
					if (pay_k == mgmt_xport_pkg::IH_VER) begin
						wptr_reg <= 8'h00;
					end
				end else begin
					wptr_reg <= wptr_reg + 8'h01;
				end
			end
			if (rx_last && frame_ok_reg) begin
				if (accept_reg) begin
					exp_seq_reg <= seq_reg + 16'h0001;
					prev_seq_reg <= seq_reg;
					have_prev_reg <= 1'b1;
					deliver_reg <= seq_reg + 16'h0001 == tot_reg;
				end else if (rc_reg != mgmt_xport_pkg::RC_VALID) begin
					have_prev_reg <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (link.c2d_valid && accept_reg &&
			rx_idx_reg >= mgmt_xport_pkg::POS_PAY &&
			!(seq_reg == 16'h0000 &&
			pay_k < mgmt_xport_pkg::INNER_HDR_LEN)) begin
			buf_mem[wptr_reg] <= link.c2d_data;
		end
		rd_data_o <= buf_mem[rd_addr_i];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			msg_valid_o <= 1'b0;
			msg_id_o <= 16'h0000;
			msg_opcode_o <= 16'h0000;
			msg_len_o <= 8'h00;
		end else begin
			msg_valid_o <= deliver_reg;
			if (deliver_reg) begin
				msg_id_o <= id_reg;
				msg_opcode_o <= op_reg;
				msg_len_o <= wptr_reg;
			end
		end
	end

	// ==========================================================
	// Acknowledgement transmit.
	logic ack_busy_reg;
	logic [8:0] tx_idx_reg;
	logic [7:0] ack_ver_reg;
	logic [15:0] ack_seq_reg;
	logic [15:0] ack_tot_reg;
	logic [7:0] ack_len_reg;
	logic [7:0] ack_rc_reg;
	logic [7:0] ack_byte;

	always_comb begin
		ack_byte = ack_rc_reg;
		if (tx_idx_reg == mgmt_xport_pkg::POS_CODE) begin
			ack_byte = mgmt_xport_pkg::CODE_ORG_SPECIFIC;
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_OUI0) begin
			ack_byte = mgmt_xport_pkg::ORG_ID[23:16];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_OUI1) begin
			ack_byte = mgmt_xport_pkg::ORG_ID[15:8];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_OUI2) begin
			ack_byte = mgmt_xport_pkg::ORG_ID[7:0];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_VER) begin
			ack_byte = ack_ver_reg;
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_TYPE) begin
			ack_byte = mgmt_xport_pkg::TYPE_ACK;
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_SEQ_HI) begin
			ack_byte = ack_seq_reg[15:8];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_SEQ_LO) begin
			ack_byte = ack_seq_reg[7:0];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_TOT_HI) begin
			ack_byte = ack_tot_reg[15:8];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_TOT_LO) begin
			ack_byte = ack_tot_reg[7:0];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_LEN) begin
			ack_byte = ack_len_reg;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_busy_reg <= 1'b0;
			tx_idx_reg <= 9'h000;
			ack_ver_reg <= 8'h00;
			ack_seq_reg <= 16'h0000;
			ack_tot_reg <= 16'h0000;
			ack_len_reg <= 8'h00;
			ack_rc_reg <= mgmt_xport_pkg::RC_VALID;
			link.d2c_data <= 8'h00;
			link.d2c_valid <= 1'b0;
			link.d2c_last <= 1'b0;
		end else begin
			link.d2c_valid <= ack_busy_reg;
			link.d2c_last <= ack_busy_reg &&
				tx_idx_reg == mgmt_xport_pkg::POS_PAY;
			link.d2c_data <= ack_busy_reg ? ack_byte : 8'h00;
			if (ack_busy_reg) begin
				tx_idx_reg <= tx_idx_reg + 9'h001;
				if (tx_idx_reg == mgmt_xport_pkg::POS_PAY) begin
					ack_busy_reg <= 1'b0;
				end
			end else if (rx_last && frame_ok_reg) begin
				ack_busy_reg <= 1'b1;
				tx_idx_reg <= mgmt_xport_pkg::POS_CODE;
				ack_ver_reg <= ver_reg;
				ack_seq_reg <= seq_reg;
				ack_tot_reg <= tot_reg;
				ack_len_reg <= len_reg;
				ack_rc_reg <= rc_reg;
			end
		end
	end
endmodule

// ---- hw/mgmt_xport_pkg.sv ----
// Constants shared by both ends of the management message transport.
// Assumes both ends run on one common clock and exchange bytes one per cycle.
package mgmt_xport_pkg;
	// ==========================================================
	// Frame layout, counted from the OAM code byte.
	localparam logic [7:0] CODE_ORG_SPECIFIC = 8'hFE;
	// Organization identifier: value is arbitrary.
	localparam logic [23:0] ORG_ID = 24'h5A3C11;
	localparam logic [7:0] TL_VERSION = 8'h01;
	localparam logic [7:0] TYPE_PDU = 8'h00;
	localparam logic [7:0] TYPE_ACK = 8'h01;
	localparam logic [7:0] MSG_VERSION = 8'h01;
	localparam logic [7:0] RESERVED_BYTE = 8'h00;
	localparam logic [8:0] POS_CODE = 9'h000;
	localparam logic [8:0] POS_OUI0 = 9'h001;
	localparam logic [8:0] POS_OUI1 = 9'h002;
	localparam logic [8:0] POS_OUI2 = 9'h003;
	localparam logic [8:0] POS_VER = 9'h004;
	localparam logic [8:0] POS_TYPE = 9'h005;
	localparam logic [8:0] POS_SEQ_HI = 9'h006;
	localparam logic [8:0] POS_SEQ_LO = 9'h007;
	localparam logic [8:0] POS_TOT_HI = 9'h008;
	localparam logic [8:0] POS_TOT_LO = 9'h009;
	localparam logic [8:0] POS_LEN = 9'h00A;
	localparam logic [8:0] POS_PAY = 9'h00B;
	// ==========================================================
	// First-fragment inner header and fragment sizes.
	localparam logic [7:0] INNER_HDR_LEN = 8'h06;
	localparam logic [7:0] IH_VER = 8'h00;
	localparam logic [7:0] IH_RSV = 8'h01;
	localparam logic [7:0] IH_ID_HI = 8'h02;
	localparam logic [7:0] IH_ID_LO = 8'h03;
	localparam logic [7:0] IH_OP_HI = 8'h04;
	localparam logic [7:0] IH_OP_LO = 8'h05;
	localparam logic [7:0] FIRST_DATA_MAX = 8'h0A;
	localparam logic [7:0] FRAG_DATA_MAX = 8'h10;
	localparam int BUF_DEPTH = 256;
	// ==========================================================
	// Response codes.
	localparam logic [7:0] RC_VALID = 8'h00;
	localparam logic [7:0] RC_BAD_VERSION = 8'h01;
	localparam logic [7:0] RC_OUT_OF_SEQ = 8'h02;
	localparam logic [7:0] RC_TOO_MANY = 8'h03;
	// ==========================================================
	// Retransmission.
	localparam logic [1:0] MAX_RETRIES = 2'h3;
	localparam int CLK_MHZ = 100;
	localparam int ACK_TIMEOUT_NS = 10000;
	localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS * CLK_MHZ / 1000;
	// ==========================================================
	// Controller registers on APB.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MSG_ID = 8'h04;
	localparam logic [7:0] REG_OPCODE = 8'h08;
	localparam logic [7:0] REG_MSG_LEN = 8'h0C;
	localparam logic [7:0] REG_DATA = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam int CTRL_START = 0;
	localparam int CTRL_CLR_PTR = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_LOST = 2;
	localparam int ST_RETRY_LSB = 4;
endpackage

// ---- hw/mgmt_link_if.sv ----
// Byte-stream link between the sending controller end and the device end.
// Assumes both ends share one clock; one byte moves per valid cycle.
`timescale 1ns/10ps
interface mgmt_link_if;
	logic [7:0] c2d_data;
	logic c2d_valid;
	logic c2d_last;
	logic [7:0] d2c_data;
	logic d2c_valid;
	logic d2c_last;
	modport dev (
		input c2d_data, c2d_valid, c2d_last,
		output d2c_data, d2c_valid, d2c_last
	);
	modport ctl (
		output c2d_data, c2d_valid, c2d_last,
		input d2c_data, d2c_valid, d2c_last
	);
endinterface

// ---- hw/mgmt_xport_ctl.sv ----
// Controller end: fragments a message and sends it stop-and-wait.
// Assumes an APB master writes the message and reads status.
`timescale 1ns/10ps
module mgmt_xport_ctl (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Link.
	mgmt_link_if.ctl link,
	// Status.
	output logic chan_lost_o
);
	typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT} tx_state_t;
	tx_state_t state_reg;
	logic [15:0] msg_id_reg;
	logic [15:0] opcode_reg;
	logic [7:0] msg_len_reg;
	logic [7:0] wr_ptr_reg;
	logic [7:0] buf_mem [mgmt_xport_pkg::BUF_DEPTH];
	logic done_reg;
	logic [1:0] retry_reg;
	logic [15:0] seq_reg;
	logic [15:0] tot_reg;
	logic [7:0] base_reg;
	logic [8:0] tx_idx_reg;
	logic [8:0] rx_idx_reg;
	logic [15:0] timer_reg;
	logic wr_acc;
	logic start_cmd;
	logic first;
	logic [7:0] remaining;
	logic [7:0] cap;
	logic [7:0] data_cnt;
	logic [7:0] flen;
	logic [7:0] k;
	logic [7:0] tx_byte;
	logic [15:0] tot_calc;
	logic frame_end;

	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign start_cmd = wr_acc && paddr_i == mgmt_xport_pkg::REG_CTRL &&
		pwdata_i[mgmt_xport_pkg::CTRL_START] && state_reg == S_IDLE;
	assign first = seq_reg == 16'h0000;
	assign remaining = msg_len_reg - base_reg;
	assign cap = first ? mgmt_xport_pkg::FIRST_DATA_MAX :
		mgmt_xport_pkg::FRAG_DATA_MAX;
	assign data_cnt = remaining < cap ? remaining : cap;
	assign flen = data_cnt + (first ? mgmt_xport_pkg::INNER_HDR_LEN : 8'h00);
	assign k = tx_idx_reg[7:0] - mgmt_xport_pkg::POS_PAY[7:0];
	assign frame_end = tx_idx_reg ==
		mgmt_xport_pkg::POS_PAY + {1'b0, flen} - 9'h001;
	assign tot_calc = msg_len_reg <= mgmt_xport_pkg::FIRST_DATA_MAX ?
		16'h0001 : 16'h0001 + (({8'h00, msg_len_reg} -
		{8'h00, mgmt_xport_pkg::FIRST_DATA_MAX} +
		{8'h00, mgmt_xport_pkg::FRAG_DATA_MAX} - 16'h0001) /
		{8'h00, mgmt_xport_pkg::FRAG_DATA_MAX});

	// ==========================================================
	// APB registers.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h00000000;
			pslverr_o <= 1'b0;
			msg_id_reg <= 16'h0000;
			opcode_reg <= 16'h0000;
			msg_len_reg <= 8'h00;
			wr_ptr_reg <= 8'h00;
		end else begin
			pready_o <= 1'b1;
			if (psel_i && !penable_i) begin
				prdata_o <= 32'h00000000;
				pslverr_o <= 1'b0;
				if (paddr_i == mgmt_xport_pkg::REG_CTRL) begin
					prdata_o <= 32'h00000000;
				end else if (paddr_i == mgmt_xport_pkg::REG_MSG_ID) begin
					prdata_o <= {16'h0000, msg_id_reg};
				end else if (paddr_i == mgmt_xport_pkg::REG_OPCODE) begin
					prdata_o <= {16'h0000, opcode_reg};
				end else if (paddr_i == mgmt_xport_pkg::REG_MSG_LEN) begin
					prdata_o <= {24'h000000, msg_len_reg};
				end else if (paddr_i == mgmt_xport_pkg::REG_DATA) begin
					prdata_o <= {24'h000000, wr_ptr_reg};
				end else if (paddr_i == mgmt_xport_pkg::REG_STATUS) begin
					prdata_o[mgmt_xport_pkg::ST_BUSY] <= state_reg != S_IDLE;
					prdata_o[mgmt_xport_pkg::ST_DONE] <= done_reg;
					prdata_o[mgmt_xport_pkg::ST_LOST] <= chan_lost_o;
					prdata_o[mgmt_xport_pkg::ST_RETRY_LSB +: 2] <= retry_reg;
				end else begin
					pslverr_o <= 1'b1;
				end
			end
			if (wr_acc && !pslverr_o) begin
				if (paddr_i == mgmt_xport_pkg::REG_CTRL &&
					pwdata_i[mgmt_xport_pkg::CTRL_CLR_PTR]) begin
					wr_ptr_reg <= 8'h00;
				end else if (paddr_i == mgmt_xport_pkg::REG_MSG_ID) begin
					msg_id_reg <= pwdata_i[15:0];
				end else if (paddr_i == mgmt_xport_pkg::REG_OPCODE) begin
					opcode_reg <= pwdata_i[15:0];
				end else if (paddr_i == mgmt_xport_pkg::REG_MSG_LEN) begin
					msg_len_reg <= pwdata_i[7:0];
				end else if (paddr_i == mgmt_xport_pkg::REG_DATA) begin
					wr_ptr_reg <= wr_ptr_reg + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_acc && !pslverr_o && paddr_i == mgmt_xport_pkg::REG_DATA) begin
			buf_mem[wr_ptr_reg] <= pwdata_i[7:0];
		end
	end

	// ==========================================================
	// Frame byte selection.
	always_comb begin
		tx_byte = buf_mem[8'(base_reg + k -
			(first ? mgmt_xport_pkg::INNER_HDR_LEN : 8'h00))];
		if (tx_idx_reg == mgmt_xport_pkg::POS_CODE) begin
			tx_byte = mgmt_xport_pkg::CODE_ORG_SPECIFIC;
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_OUI0) begin
			tx_byte = mgmt_xport_pkg::ORG_ID[23:16];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_OUI1) begin
			tx_byte = mgmt_xport_pkg::ORG_ID[15:8];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_OUI2) begin
			tx_byte = mgmt_xport_pkg::ORG_ID[7:0];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_VER) begin
			tx_byte = mgmt_xport_pkg::TL_VERSION;
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_TYPE) begin
			tx_byte = mgmt_xport_pkg::TYPE_PDU;
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_SEQ_HI) begin
			tx_byte = seq_reg[15:8];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_SEQ_LO) begin
			tx_byte = seq_reg[7:0];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_TOT_HI) begin
			tx_byte = tot_reg[15:8];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_TOT_LO) begin
			tx_byte = tot_reg[7:0];
		end else if (tx_idx_reg == mgmt_xport_pkg::POS_LEN) begin
			tx_byte = flen;
		end else if (first && k < mgmt_xport_pkg::INNER_HDR_LEN) begin
			case (k)
				mgmt_xport_pkg::IH_VER: tx_byte = mgmt_xport_pkg::MSG_VERSION;
				mgmt_xport_pkg::IH_RSV: tx_byte = mgmt_xport_pkg::RESERVED_BYTE;
				mgmt_xport_pkg::IH_ID_HI: tx_byte = msg_id_reg[15:8];
				mgmt_xport_pkg::IH_ID_LO: tx_byte = msg_id_reg[7:0];
				mgmt_xport_pkg::IH_OP_HI: tx_byte = opcode_reg[15:8];
				default: tx_byte = opcode_reg[7:0];
			endcase
		end
	end

	// ==========================================================
	// Stop-and-wait sender.
	logic ack_last;
	logic ack_hit;
	logic [7:0] ack_type_reg;
	logic [15:0] ack_seq_reg;
	logic ack_ok_reg;

	assign ack_last = link.d2c_valid && link.d2c_last;
	assign ack_hit = ack_last && ack_ok_reg &&
		ack_type_reg == mgmt_xport_pkg::TYPE_ACK && ack_seq_reg == seq_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_idx_reg <= 9'h000;
			ack_ok_reg <= 1'b0;
			ack_type_reg <= 8'h00;
			ack_seq_reg <= 16'h0000;
		end else if (link.d2c_valid) begin
			rx_idx_reg <= link.d2c_last ? 9'h000 : rx_idx_reg + 9'h001;
			if (rx_idx_reg == mgmt_xport_pkg::POS_CODE) begin
				ack_ok_reg <= link.d2c_data == mgmt_xport_pkg::CODE_ORG_SPECIFIC;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_TYPE) begin
				ack_type_reg <= link.d2c_data;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_SEQ_HI) begin
				ack_seq_reg[15:8] <= link.d2c_data;
			end else if (rx_idx_reg == mgmt_xport_pkg::POS_SEQ_LO) begin
				ack_seq_reg[7:0] <= link.d2c_data;
			end else if (rx_idx_reg < mgmt_xport_pkg::POS_PAY) begin
				ack_ok_reg <= ack_ok_reg;
			end else if (rx_idx_reg > mgmt_xport_pkg::POS_PAY) begin
				ack_ok_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= S_IDLE;
			seq_reg <= 16'h0000;
			tot_reg <= 16'h0000;
			base_reg <= 8'h00;
			tx_idx_reg <= 9'h000;
			timer_reg <= 16'h0000;
			retry_reg <= 2'h0;
			done_reg <= 1'b0;
			chan_lost_o <= 1'b0;
			link.c2d_data <= 8'h00;
			link.c2d_valid <= 1'b0;
			link.c2d_last <= 1'b0;
		end else begin
			link.c2d_valid <= 1'b0;
			link.c2d_last <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (start_cmd) begin
						state_reg <= S_SEND;
						seq_reg <= 16'h0000;
						tot_reg <= tot_calc;
						base_reg <= 8'h00;
						tx_idx_reg <= 9'h000;
						retry_reg <= 2'h0;
						done_reg <= 1'b0;
						chan_lost_o <= 1'b0;
					end
				end
				S_SEND: begin
					link.c2d_valid <= 1'b1;
					link.c2d_data <= tx_byte;
					link.c2d_last <= frame_end;
					tx_idx_reg <= tx_idx_reg + 9'h001;
					if (frame_end) begin
						state_reg <= S_WAIT;
						timer_reg <= 16'h0000;
					end
				end
				default: begin
					timer_reg <= timer_reg + 16'h0001;
					tx_idx_reg <= 9'h000;
					if (ack_hit && link.d2c_data == mgmt_xport_pkg::RC_VALID &&
						rx_idx_reg == mgmt_xport_pkg::POS_PAY) begin
						retry_reg <= 2'h0;
						if (seq_reg + 16'h0001 == tot_reg) begin
							state_reg <= S_IDLE;
							done_reg <= 1'b1;
						end else begin
							state_reg <= S_SEND;
							seq_reg <= seq_reg + 16'h0001;
							base_reg <= base_reg + data_cnt;
						end
					end else if (ack_hit ||
						timer_reg == 16'(mgmt_xport_pkg::ACK_TIMEOUT_CYC - 1)) begin
						if (retry_reg == mgmt_xport_pkg::MAX_RETRIES) begin
							state_reg <= S_IDLE;
							chan_lost_o <= 1'b1;
						end else begin
							state_reg <= S_SEND;
							retry_reg <= retry_reg + 2'h1;
						end
					end
				end
			endcase
		end
	end
endmodule

// ---- tb/mgmt_xport_checker.sv ----
// Link checker for the two transport ends.
// Assumes one clock and the link signals wired in as plain inputs.
`timescale 1ns/10ps
module mgmt_xport_checker (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Link.
	input wire logic [7:0] c2d_data,
	input wire logic c2d_valid,
	input wire logic c2d_last,
	input wire logic [7:0] d2c_data,
	input wire logic d2c_valid,
	input wire logic d2c_last
);
	// ======================================================
	// Byte positions within the frames on each direction.
	logic [7:0] c_reg;
	logic [7:0] d_reg;
	logic [7:0] len_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			c_reg <= 8'h00;
			d_reg <= 8'h00;
			len_reg <= 8'h00;
		end else begin
			if (c2d_valid) c_reg <= c2d_last ? 8'h00 : c_reg + 8'h01;
			if (d2c_valid) d_reg <= d2c_last ? 8'h00 : d_reg + 8'h01;
			if (c2d_valid && c_reg == 8'h0A) len_reg <= c2d_data;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_code; c2d_valid && c_reg == 8'h00 |-> c2d_data == 8'hFE;
	endproperty
	a_code: assert property (p_code) else $error("code byte");
	property p_oui; c2d_valid && c_reg == 8'h01 |-> c2d_data == 8'h5A;
	endproperty
	a_oui: assert property (p_oui) else $error("org id byte");
	property p_ver; c2d_valid && c_reg == 8'h04 |-> c2d_data == 8'h01;
	endproperty
	a_ver: assert property (p_ver) else $error("version byte");
	property p_type; c2d_valid && c_reg == 8'h05 |-> c2d_data == 8'h00;
	endproperty
	a_type: assert property (p_type) else $error("type byte");
	property p_len; c2d_valid && c2d_last |-> c_reg == len_reg + 8'h0A;
	endproperty
	a_len: assert property (p_len) else $error("frame length");
	property p_ack; c2d_valid && c2d_last |-> ##2 d2c_valid && d_reg == 0;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_atype; d2c_valid && d_reg == 8'h05 |-> d2c_data == 8'h01;
	endproperty
	a_atype: assert property (p_atype) else $error("ack type");
	property p_alen; d2c_valid && d2c_last |-> d_reg == 8'h0B;
	endproperty
	a_alen: assert property (p_alen) else $error("ack length");
	property p_one; d2c_valid |-> !c2d_valid;
	endproperty
	a_one: assert property (p_one) else $error("send during ack");
endmodule

// ---- tb/tb_mgmt_msg_oam_transport.sv ----
// Bench joining both transport ends, plus a second sender with no acks.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/10ps
module tb_mgmt_msg_oam_transport;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, rd_addr = 8'h00, mlen, rdata;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, perr, lost1, lost2, mvalid;
	logic [15:0] mid, mop;
	int bad_count = 0, samples_checked = 0, cyc = 0, frames2 = 0;
	mgmt_link_if link ();
	mgmt_link_if link2 ();
	assign link2.d2c_valid = 1'b0;
	assign link2.d2c_last = 1'b0;
	assign link2.d2c_data = cyc[7:0];
	mgmt_xport_dev mgmt_xport_dev_i (.clk_i, .rst_n_i, .link(link.dev),
		.chan_reinit_i(lost1), .msg_valid_o(mvalid), .msg_id_o(mid),
		.msg_opcode_o(mop), .msg_len_o(mlen), .rd_addr_i(rd_addr),
		.rd_data_o(rdata));
	mgmt_xport_ctl mgmt_xport_ctl_i (.clk_i, .rst_n_i, .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .link(link.ctl), .chan_lost_o(lost1));
	mgmt_xport_ctl mgmt_xport_ctl_b_i (.clk_i, .rst_n_i, .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(), .pready_o(), .pslverr_o(),
		.link(link2.ctl), .chan_lost_o(lost2));
	mgmt_xport_checker mgmt_xport_checker_i (.clk_i, .rst_n_i,
		.c2d_data(link.c2d_data), .c2d_valid(link.c2d_valid),
		.c2d_last(link.c2d_last), .d2c_data(link.d2c_data),
		.d2c_valid(link.d2c_valid), .d2c_last(link.d2c_last));
	// ======================================================
	// Shared tasks.
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ======================================================
	// Scenarios.
	task automatic send(logic [7:0] n);
		apb(1'b1, 8'h04, {16'h0, 8'h12, n});
		apb(1'b1, 8'h08, {16'h0, 8'h03, n});
		apb(1'b1, 8'h0C, {24'h0, n});
		apb(1'b1, 8'h00, 32'h2);
		for (int i = 0; i < n; i++) apb(1'b1, 8'h10, 32'h30 + i);
		apb(1'b1, 8'h00, 32'h1);
		while (mvalid !== 1'b1) @(negedge clk_i);
		chk("id", {8'h12, n}, mid);
		chk("opcode", {8'h03, n}, mop);
		chk("length", n, mlen);
		@(posedge clk_i);
		rd_addr <= n - 8'h01;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("last byte", 8'h2F + n, rdata);
		do apb(1'b0, 8'h14, 32'h0); while (rdat[0] !== 1'b0);
		chk("status", 3'h2, rdat[2:0]);
	endtask
	task automatic wait_lost();
		while (lost2 !== 1'b1) @(negedge clk_i);
		chk("sends", 4, frames2);
		chk("lost", 1'b0, lost1);
	endtask
	task automatic bad_addr();
		apb(1'b0, 8'hF0, 32'h0);
		chk("slverr", 1'b1, perr);
		chk("rdata", 32'h0, rdat);
	endtask
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (link2.c2d_valid && link2.c2d_last) frames2 <= frames2 + 1;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		send(8'h04);
		wait_lost();
		send(8'h0A);
		send(8'h0B);
		send(8'h1E);
		bad_addr();
		give_verdict();
	end
endmodule
